// ==== core/cdrlk_lock_det.sv ====
// Purpose: Frequency lock detector with acquire and loss thresholds.
// Assumes: Error magnitudes in ppm arrive from logic on the core clock.
// Notes:   Lock loss is high from reset until the first acquisition.

`timescale 1ns/1ns

module cdrlk_lock_det #(
  parameter int                ERR_W = 12,
  parameter logic [ERR_W-1:0]  ACQ   = cdrlk_pkg::ACQ_PPM,
  parameter logic [ERR_W-1:0]  LOSS  = cdrlk_pkg::LOSS_PPM
) (
  // Clock and reset.
  input  wire logic             clock_i,
  input  wire logic             rst_b_i,
  // Mode and measured errors.
  input  wire logic             ref_assist_i,
  input  wire logic [ERR_W-1:0] data_err_i,
  input  wire logic [ERR_W-1:0] ref_err_i,
  // Live lock loss.
  output logic                  lock_loss_o
);

  // Refuse a window whose acquire level is not below its loss level.
  if (ACQ >= LOSS) begin : g_bad_thresholds
    $error("Acquire threshold must lie below the loss threshold.");
  end

  ////////////////////////////////////////////////////////////////////////////////
  logic [ERR_W-1:0] err;
  logic             next_lock_loss;

  // Pick the error against the reference or against the data.
  assign err = ref_assist_i ? ref_err_i : data_err_i;
  // Release inside the acquire window, reassert only beyond the loss level.
  assign next_lock_loss = lock_loss_o ? (err > ACQ) : (err > LOSS);

  // Hysteresis state.
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      lock_loss_o <= 1'b1;
    end else begin
      lock_loss_o <= next_lock_loss;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  AST_RELEASE: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    lock_loss_o && err <= ACQ |=> !lock_loss_o)
    else $error("Lock loss not released inside the acquire window.");

  AST_REASSERT: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    !lock_loss_o && err > LOSS |=> lock_loss_o)
    else $error("Lock loss not reasserted beyond the loss level.");

  AST_HYST: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    lock_loss_o && err > ACQ |=> lock_loss_o)
    else $error("Lock loss released outside the acquire window.");

endmodule : cdrlk_lock_det

// ==== core/cdrlk_pkg.sv ====
// Purpose: Shared constants and types of the lock and serial control block.
// Assumes: Eight-bit registers reached by subaddress over the two-wire link.
// Notes:   Every offset, field position, reset value and threshold lives here.

package cdrlk_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Link addressing and subaddress map.
  localparam logic [5:0] ADDR_HI    = 6'h20;
  localparam logic [7:0] SUB_STATUS = 8'h06;
  localparam logic [7:0] SUB_MODE   = 8'h08;
  localparam logic [7:0] SUB_CFG    = 8'h09;
  localparam logic [7:0] SUB_REFCTL = 8'h0A;
  localparam logic [7:0] SUB_REFLK  = 8'h0F;
  localparam logic [7:0] SUB_OUT    = 8'h1E;
  localparam logic [7:0] SUB_MAX    = 8'h1E;

  ////////////////////////////////////////////////////////////////////////////////
  // Field positions.
  localparam int MODE_LSB   = 4;
  localparam int STICKY_BIT = 2;
  localparam int CLR_BIT    = 2;
  localparam int PINSEL_BIT = 4;
  localparam int SQ_BIT     = 5;
  localparam int DOFF_BIT   = 4;
  localparam int COFF_BIT   = 3;
  localparam int POL_BIT    = 1;
  localparam logic [2:0] MODE_REF = 3'h3;

  ////////////////////////////////////////////////////////////////////////////////
  // Reset values and thresholds.
  localparam logic [7:0]  RST_MODE   = 8'h00;
  localparam logic [7:0]  RST_CFG    = 8'h00;
  localparam logic [7:0]  RST_REFCTL = 8'h05;
  localparam logic [7:0]  RST_REFLK  = 8'h00;
  localparam logic [7:0]  RST_OUT    = 8'h00;
  localparam logic [11:0] ACQ_PPM    = 12'h0FA;
  localparam logic [11:0] LOSS_PPM   = 12'h3E8;
  localparam logic [3:0]  BIT_LAST   = 4'h7;
  localparam logic [3:0]  BIT_ACK    = 4'h8;

  ////////////////////////////////////////////////////////////////////////////////
  // Types.
  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_ADDR  = 5'h02,
    ST_SUB   = 5'h04,
    ST_WDATA = 5'h08,
    ST_RDATA = 5'h10
  } cdrlk_st_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } cdrlk_wr_t;

  typedef struct packed {
    logic       sticky;
    logic [7:0] mode;
    logic [7:0] cfg;
    logic [7:0] refctl;
    logic [7:0] reflk;
    logic [7:0] outc;
  } cdrlk_rb_t;

endpackage : cdrlk_pkg

// ==== core/cdrlk_top.sv ====
// Purpose: Lock detect, sticky lock flag, output control and two-wire slave.
// Assumes: scl_i clocks the serial side; clock_i clocks the control side.
// Notes:   Register writes cross to the core by toggle; readback by two flops.

`timescale 1ns/1ns

// Overview of operation
// - Free-running: release lock loss when error is within 250 ppm.
// - Locked: reassert lock loss above 1000 ppm; hold until back within 250 ppm.
// - Recovery mode field value 3 selects reference-assisted lock.
// - Reference mode compares against the divided reference with same thresholds.
// - Sticky flag sets on any lock loss and stays set after relock.
// - Writing one then zero to the clear bit clears the sticky flag.
// - Pin-select bit makes the lock pin mirror the sticky flag.
// - Data-off disables data and clock outputs; clock-off disables clock only.
// - Squelch keeps the driver on and forces data to the polarity bit.
// - Answer address 100000 plus select pin; direction bit one means read.
// - Acknowledge a matching address on the ninth clock; otherwise go idle.
// - Second byte is the subaddress; it increments after each written byte and after each acknowledged read byte below the top subaddress.
// - Start or stop anywhere forces a return to address or idle on the next falling clock edge.
// - Invalid subaddress gets no acknowledge and the slave goes idle.
// - Reads past the top subaddress keep returning the top register.
module cdrlk_top (
  // Core clock and reset.
  input  wire logic        clock_i,
  input  wire logic        rst_b_i,
  // Two-wire link.
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_o,
  input  wire logic        addr_sel_i,
  // Frequency error measurements.
  input  wire logic [11:0] data_err_ppm_i,
  input  wire logic [11:0] ref_err_ppm_i,
  // Recovered data path.
  input  wire logic        data_i,
  output logic             data_o,
  output logic             data_out_off_o,
  output logic             clock_out_off_o,
  // Lock and reference control.
  output logic             lock_loss_flag_o,
  output logic             ref_assist_o,
  output logic [2:0]       recovery_mode_sel_o,
  output logic [7:0]       ref_clock_control_o,
  output logic [7:0]       ref_lock_config_o
);

  ////////////////////////////////////////////////////////////////////////////////
  // Readback selection, clamped to the top subaddress.
  function automatic logic [7:0] rd_byte(input logic [7:0] sub,
                                         input cdrlk_pkg::cdrlk_rb_t rb);
    logic [7:0] a;
    logic [7:0] r;
    a = (sub > cdrlk_pkg::SUB_MAX) ? cdrlk_pkg::SUB_MAX : sub;
    r = 8'h00;
    case (a)
      cdrlk_pkg::SUB_STATUS: r[cdrlk_pkg::STICKY_BIT] = rb.sticky;
      cdrlk_pkg::SUB_MODE:   r = rb.mode;
      cdrlk_pkg::SUB_CFG:    r = rb.cfg;
      cdrlk_pkg::SUB_REFCTL: r = rb.refctl;
      cdrlk_pkg::SUB_REFLK:  r = rb.reflk;
      cdrlk_pkg::SUB_OUT:    r = rb.outc;
      default:               r = 8'h00;
    endcase
    return r;
  endfunction : rd_byte

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations.
  cdrlk_pkg::cdrlk_st_t st;
  cdrlk_pkg::cdrlk_st_t next_st;
  cdrlk_pkg::cdrlk_wr_t wr_q;
  cdrlk_pkg::cdrlk_wr_t next_wr;
  cdrlk_pkg::cdrlk_rb_t rb_core;
  cdrlk_pkg::cdrlk_rb_t rb_m;
  cdrlk_pkg::cdrlk_rb_t rb_s;
  logic [3:0]           cnt;
  logic [3:0]           next_cnt;
  logic [7:0]           sh;
  logic [7:0]           next_sh;
  logic [7:0]           rd_sh;
  logic [7:0]           next_rd;
  logic [7:0]           ptr;
  logic [7:0]           next_ptr;
  logic [7:0]           ptr_rd;
  logic [7:0]           byte_in;
  logic [7:0]           rd_cur;
  logic [7:0]           rd_next;
  logic                 rw;
  logic                 next_rw;
  logic                 next_oe;
  logic                 wr_tog;
  logic                 next_wr_tog;
  logic                 start_tog;
  logic                 stop_tog;
  logic                 start_seen;
  logic                 stop_seen;
  logic                 start_ev;
  logic                 stop_ev;
  logic                 bit_r;
  logic                 asel_m;
  logic                 asel_s;
  logic                 addr_hit;
  logic                 sub_ok;
  logic                 ptr_ok;
  logic                 last_bit;
  logic                 ack_bit;
  logic                 wt_m;
  logic                 wt_s;
  logic                 wt_d;
  logic                 wr_fire;
  logic [7:0]           mode_reg;
  logic [7:0]           cfg_reg;
  logic [7:0]           refctl_reg;
  logic [7:0]           reflk_reg;
  logic [7:0]           out_reg;
  logic                 sticky;
  logic                 next_sticky;
  logic                 clr_d;
  logic                 clr_fall;
  logic                 lol_live;
  logic                 ref_mode;

  ////////////////////////////////////////////////////////////////////////////////
  // Start and stop marks: sda edges while scl is high flip a toggle.
  always_ff @(negedge sda_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      start_tog <= 1'b0;
    end else if (scl_i) begin
      start_tog <= ~start_tog;
    end
  end

  always_ff @(posedge sda_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      stop_tog <= 1'b0;
    end else if (scl_i) begin
      stop_tog <= ~stop_tog;
    end
  end

  // Rising scl samples data; address pin and readback pass two flops.
  always_ff @(posedge scl_i) begin
    bit_r  <= sda_i;
    asel_m <= addr_sel_i;
    asel_s <= asel_m;
    rb_m   <= rb_core;
    rb_s   <= rb_m;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Serial-side decoding.
  assign start_ev = start_tog ^ start_seen;
  assign stop_ev  = stop_tog ^ stop_seen;
  assign byte_in  = {sh[6:0], bit_r};
  assign addr_hit = byte_in[7:1] == {cdrlk_pkg::ADDR_HI, asel_s};
  assign sub_ok   = byte_in <= cdrlk_pkg::SUB_MAX;
  assign ptr_ok   = ptr <= cdrlk_pkg::SUB_MAX;
  assign ptr_rd   = (ptr < cdrlk_pkg::SUB_MAX) ? 8'(ptr + 8'h01) : ptr;
  assign last_bit = cnt == cdrlk_pkg::BIT_LAST;
  assign ack_bit  = cnt == cdrlk_pkg::BIT_ACK;
  assign rd_cur   = rd_byte(ptr, rb_s);
  assign rd_next  = rd_byte(ptr_rd, rb_s);

  // Slave sequencer, evaluated for each falling scl edge.
  always_comb begin
    next_st     = st;
    next_cnt    = cnt;
    next_sh     = byte_in;
    next_oe     = 1'b0;
    next_rd     = {rd_sh[6:0], 1'b0};
    next_ptr    = ptr;
    next_rw     = rw;
    next_wr_tog = wr_tog;
    next_wr     = wr_q;
    if (start_ev) begin
      next_st  = cdrlk_pkg::ST_ADDR;
      next_cnt = 4'h0;
    end else if (stop_ev) begin
      next_st  = cdrlk_pkg::ST_IDLE;
      next_cnt = 4'h0;
    end else if (ack_bit) begin
      next_cnt = 4'h0;
      unique case (st)
        cdrlk_pkg::ST_IDLE: next_cnt = cnt;
        cdrlk_pkg::ST_ADDR: begin
          if (rw) begin
            next_st = cdrlk_pkg::ST_RDATA;
            next_oe = ~rd_cur[7];
            next_rd = {rd_cur[6:0], 1'b0};
          end else begin
            next_st = cdrlk_pkg::ST_SUB;
          end
        end
        cdrlk_pkg::ST_SUB: next_st = cdrlk_pkg::ST_WDATA;
        cdrlk_pkg::ST_WDATA: begin
          next_wr_tog = ~wr_tog;
          next_wr     = '{addr: ptr, data: sh};
          next_ptr    = 8'(ptr + 8'h01);
        end
        cdrlk_pkg::ST_RDATA: begin
          if (bit_r) begin
            next_st = cdrlk_pkg::ST_IDLE;
          end else begin
            next_ptr = ptr_rd;
            next_oe  = ~rd_next[7];
            next_rd  = {rd_next[6:0], 1'b0};
          end
        end
        default: next_st = cdrlk_pkg::ST_IDLE;
      endcase
    end else if (st != cdrlk_pkg::ST_IDLE) begin
      next_cnt = 4'(cnt + 4'h1);
      if (st == cdrlk_pkg::ST_RDATA && !last_bit) begin
        next_oe = ~rd_sh[7];
      end
      if (last_bit) begin
        unique case (st)
          cdrlk_pkg::ST_ADDR: begin
            next_oe = addr_hit;
            next_rw = byte_in[0];
            if (!addr_hit) begin
              next_st = cdrlk_pkg::ST_IDLE;
            end
          end
          cdrlk_pkg::ST_SUB: begin
            next_oe  = sub_ok;
            next_ptr = byte_in;
            if (!sub_ok) begin
              next_st = cdrlk_pkg::ST_IDLE;
            end
          end
          cdrlk_pkg::ST_WDATA: begin
            next_oe = ptr_ok;
            if (!ptr_ok) begin
              next_st = cdrlk_pkg::ST_IDLE;
            end
          end
          cdrlk_pkg::ST_RDATA: next_oe = 1'b0;
          default: next_st = cdrlk_pkg::ST_IDLE;
        endcase
      end
    end
  end

  // Serial-side state; the link clock stands still between frames.
  always_ff @(negedge scl_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st         <= cdrlk_pkg::ST_IDLE;
      cnt        <= 4'h0;
      sh         <= 8'h00;
      rd_sh      <= 8'h00;
      ptr        <= 8'h00;
      rw         <= 1'b0;
      wr_tog     <= 1'b0;
      wr_q       <= '0;
      start_seen <= 1'b0;
      stop_seen  <= 1'b0;
      sda_oe_o   <= 1'b0;
      sda_o      <= 1'b0;
    end else begin
      st         <= next_st;
      cnt        <= next_cnt;
      sh         <= next_sh;
      rd_sh      <= next_rd;
      ptr        <= next_ptr;
      rw         <= next_rw;
      wr_tog     <= next_wr_tog;
      wr_q       <= next_wr;
      start_seen <= start_tog;
      stop_seen  <= stop_tog;
      sda_oe_o   <= next_oe;
      sda_o      <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Write toggle crosses into the core; the held word is read on its edge.
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      wt_m <= 1'b0;
      wt_s <= 1'b0;
      wt_d <= 1'b0;
    end else begin
      wt_m <= wr_tog;
      wt_s <= wt_m;
      wt_d <= wt_s;
    end
  end

  assign wr_fire = wt_s ^ wt_d;

  // Register file in the core domain.
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      mode_reg   <= cdrlk_pkg::RST_MODE;
      cfg_reg    <= cdrlk_pkg::RST_CFG;
      refctl_reg <= cdrlk_pkg::RST_REFCTL;
      reflk_reg  <= cdrlk_pkg::RST_REFLK;
      out_reg    <= cdrlk_pkg::RST_OUT;
    end else if (wr_fire) begin
      if (wr_q.addr == cdrlk_pkg::SUB_MODE)   mode_reg   <= wr_q.data;
      if (wr_q.addr == cdrlk_pkg::SUB_CFG)    cfg_reg    <= wr_q.data;
      if (wr_q.addr == cdrlk_pkg::SUB_REFCTL) refctl_reg <= wr_q.data;
      if (wr_q.addr == cdrlk_pkg::SUB_REFLK)  reflk_reg  <= wr_q.data;
      if (wr_q.addr == cdrlk_pkg::SUB_OUT)    out_reg    <= wr_q.data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Lock detector.
  assign ref_mode = mode_reg[cdrlk_pkg::MODE_LSB +: 3] == cdrlk_pkg::MODE_REF;

  cdrlk_lock_det #(
    .ERR_W (12)
  ) u_lock (
    .clock_i      (clock_i),
    .rst_b_i      (rst_b_i),
    .ref_assist_i (ref_assist_o),
    .data_err_i   (data_err_ppm_i),
    .ref_err_i    (ref_err_ppm_i),
    .lock_loss_o  (lol_live)
  );

  // Sticky flag: a one-then-zero on the clear bit clears; loss wins.
  assign clr_fall    = clr_d & ~mode_reg[cdrlk_pkg::CLR_BIT];
  assign next_sticky = lol_live | (sticky & ~clr_fall);
  assign rb_core     = '{sticky: sticky, mode: mode_reg, cfg: cfg_reg,
                         refctl: refctl_reg, reflk: reflk_reg, outc: out_reg};

  // Status, pin and output control flops.
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      sticky              <= 1'b0;
      clr_d               <= 1'b0;
      lock_loss_flag_o    <= 1'b1;
      ref_assist_o        <= 1'b0;
      recovery_mode_sel_o <= 3'h0;
      ref_clock_control_o <= cdrlk_pkg::RST_REFCTL;
      ref_lock_config_o   <= cdrlk_pkg::RST_REFLK;
      data_out_off_o      <= 1'b0;
      clock_out_off_o     <= 1'b0;
      data_o              <= 1'b0;
    end else begin
      sticky              <= next_sticky;
      clr_d               <= mode_reg[cdrlk_pkg::CLR_BIT];
      lock_loss_flag_o    <= cfg_reg[cdrlk_pkg::PINSEL_BIT] ? sticky : lol_live;
      ref_assist_o        <= ref_mode;
      recovery_mode_sel_o <= mode_reg[cdrlk_pkg::MODE_LSB +: 3];
      ref_clock_control_o <= refctl_reg;
      ref_lock_config_o   <= reflk_reg;
      data_out_off_o      <= out_reg[cdrlk_pkg::DOFF_BIT];
      clock_out_off_o     <= out_reg[cdrlk_pkg::DOFF_BIT] | out_reg[cdrlk_pkg::COFF_BIT];
      data_o              <= out_reg[cdrlk_pkg::DOFF_BIT] ? 1'b0 :
                             out_reg[cdrlk_pkg::SQ_BIT] ? out_reg[cdrlk_pkg::POL_BIT] :
                             data_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Core-side checks.
  AST_STICKY_SET: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    lol_live |=> sticky ##1 (sticky || $past(clr_fall)))
    else $error("Sticky flag not set by lock loss.");

  AST_STICKY_CLEAR: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    clr_fall && !lol_live |=> !sticky)
    else $error("Sticky flag not cleared by one-then-zero.");

  AST_PIN_MIRROR: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    cfg_reg[cdrlk_pkg::PINSEL_BIT] |=> lock_loss_flag_o == $past(sticky))
    else $error("Lock pin does not mirror the sticky flag.");

  AST_DATA_OFF: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    out_reg[cdrlk_pkg::DOFF_BIT] |=> data_out_off_o && clock_out_off_o)
    else $error("Data-off did not disable both outputs.");

  AST_SQUELCH: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    out_reg[cdrlk_pkg::SQ_BIT] && !out_reg[cdrlk_pkg::DOFF_BIT]
    |=> data_o == $past(out_reg[cdrlk_pkg::POL_BIT]) && !data_out_off_o)
    else $error("Squelched data not held at the polarity level.");

  AST_REF_MODE: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    ref_mode |=> ref_assist_o)
    else $error("Mode value 3 did not select reference assist.");

  AST_WR_ONLY_AFTER_ACK: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    $changed(mode_reg) |-> $past(wr_fire))
    else $error("Mode register changed without a committed write.");

  // Serial-side checks.
  sequence s_addr_done;
    st == cdrlk_pkg::ST_ADDR && last_bit && !start_ev && !stop_ev;
  endsequence

  AST_ACK_MATCH: assert property (@(negedge scl_i) disable iff (!rst_b_i)
    s_addr_done and addr_hit |=> sda_oe_o && st == cdrlk_pkg::ST_ADDR)
    else $error("Matching address not acknowledged.");

  AST_NO_MATCH_IDLE: assert property (@(negedge scl_i) disable iff (!rst_b_i)
    s_addr_done and !addr_hit |=> !sda_oe_o && st == cdrlk_pkg::ST_IDLE)
    else $error("Foreign address not dropped to idle.");

  AST_BAD_SUB: assert property (@(negedge scl_i) disable iff (!rst_b_i)
    st == cdrlk_pkg::ST_SUB && last_bit && !start_ev && !stop_ev && !sub_ok
    |=> !sda_oe_o && st == cdrlk_pkg::ST_IDLE)
    else $error("Invalid subaddress was acknowledged.");

  AST_START: assert property (@(negedge scl_i) disable iff (!rst_b_i)
    start_ev |=> st == cdrlk_pkg::ST_ADDR && cnt == 4'h0 && !sda_oe_o)
    else $error("Start did not restart the address phase.");

endmodule : cdrlk_top

// ==== sim/cdrlk_master.sv ====
// Purpose: Two-wire bus master model for the serial link.
// Assumes: The bench resolves the open-drain data wire with a pull-up.
// Notes:   Clock stands high between frames; bit period is 80 ns.

`timescale 1ns/1ns

module cdrlk_master (
  // Bus lines.
  output logic      scl_o,
  output logic      pull_o,
  input  wire logic sda_i
);
  // Idle bus: clock high, data released.
  initial begin
    scl_o  = 1'b1;
    pull_o = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Start or repeated start, a single one per clock high period.
  task automatic start();
    #20 pull_o = 1'b0;
    #20 scl_o = 1'b1;
    #20 pull_o = 1'b1;
    #20 scl_o = 1'b0;
  endtask : start

  // Stop, then the bus idles high.
  task automatic stop();
    #20 pull_o = 1'b1;
    #20 scl_o = 1'b1;
    #20 pull_o = 1'b0;
    #20;
  endtask : stop

  // Eight bits MSB first, then the acknowledge slot; data moves only while the clock is low.
  task automatic xfer(input logic [7:0] tx, input logic nack,
                      output logic [7:0] rx, output logic ack);
    logic [8:0] sh;
    logic [8:0] rv;
    sh = {tx, nack};
    for (int i = 8; i >= 0; i--) begin
      #20 pull_o = !sh[i];
      #20 scl_o = 1'b1;
      #20 rv[i] = sda_i;
      #20 scl_o = 1'b0;
    end
    rx  = rv[8:1];
    ack = rv[0];
  endtask : xfer
endmodule : cdrlk_master

// ==== sim/test_cdr_lock_and_serial_control.sv ====
// Purpose: Self-checking bench for the lock and serial control block.
// Assumes: Registers are reached only through the two-wire master model.
// Notes:   Waits after writes cover the crossing into the core domain.

`timescale 1ns/1ns

module test_cdr_lock_and_serial_control;
  // Bench signals.
  logic        clock_i;
  logic        rst_b_i;
  logic        asel;
  logic [11:0] derr;
  logic [11:0] rerr;
  logic        din;
  logic        scl;
  logic        pull;
  logic        sda_o;
  logic        sda_oe;
  logic        data_o;
  logic        doff;
  logic        coff;
  logic        lock_loss_flag;
  logic        refa;
  logic [2:0]  mode;
  logic [7:0]  rctl;
  logic [7:0]  rlk;
  logic [7:0]  rx;
  logic        ack;
  int          fail_count;
  int          tests_run;
  logic [7:0]  ov[4] = '{8'h10, 8'h08, 8'h20, 8'h22};
  logic [7:0]  ox[4] = '{8'h06, 8'h03, 8'h00, 8'h01};
  wire         sda = (pull || (sda_oe && !sda_o)) ? 1'b0 : 1'b1;

  // Device and bus master.
  cdrlk_top dut (.clock_i(clock_i), .rst_b_i(rst_b_i), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe_o(sda_oe), .addr_sel_i(asel), .data_err_ppm_i(derr),
    .ref_err_ppm_i(rerr), .data_i(din), .data_o(data_o), .data_out_off_o(doff),
    .clock_out_off_o(coff), .lock_loss_flag_o(lock_loss_flag), .ref_assist_o(refa),
    .recovery_mode_sel_o(mode), .ref_clock_control_o(rctl), .ref_lock_config_o(rlk));
  cdrlk_master m (.scl_o(scl), .pull_o(pull), .sda_i(sda));

  ////////////////////////////////////////////////////////////////////////////////
  // Core clock.
  initial begin
    clock_i = 1'b0;
    forever #20 clock_i = ~clock_i;
  end

  // Compare and count.
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // Verdict and end of run.
  task automatic test_done();
    if (fail_count == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : test_done

  // New error figures just after an edge, then let the detector and pin settle.
  task automatic core(input logic [11:0] de, input logic [11:0] re);
    @(posedge clock_i);
    #2 derr = de;
    rerr = re;
    repeat (3) @(posedge clock_i);
    #2;
  endtask : core

  // Write-direction address, then the subaddress byte.
  task automatic head(input logic [7:0] sub);
    m.start();
    m.xfer({cdrlk_pkg::ADDR_HI, asel, 1'b0}, 1'b1, rx, ack);
    chk(8'(ack), 8'h00);
    m.xfer(sub, 1'b1, rx, ack);
  endtask : head

  // Stop and wait out the crossing into the core.
  task automatic fin();
    m.stop();
    repeat (8) @(posedge clock_i);
    #2;
  endtask : fin

  task automatic wr(input logic [7:0] sub, input logic [7:0] d);
    head(sub);
    m.xfer(d, 1'b1, rx, ack);
    chk(8'(ack), 8'h00);
    fin();
  endtask : wr

  // Read n bytes; the master acknowledges all but the last.
  task automatic rd(input logic [7:0] sub, input logic [7:0] msk,
                    input logic [7:0] exp, input int n);
    head(sub);
    m.start();
    m.xfer({cdrlk_pkg::ADDR_HI, asel, 1'b1}, 1'b1, rx, ack);
    for (int i = n; i > 0; i--) begin
      m.xfer(8'hFF, i == 1, rx, ack);
      chk(rx & msk, exp);
    end
    m.stop();
  endtask : rd

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    rst_b_i = 1'b0;
    asel = 1'b1;
    derr = 12'hFFF;
    rerr = 12'hFFF;
    din = 1'b1;
    fail_count = 0;
    tests_run = 0;
    repeat (8) @(posedge clock_i);
    #2 rst_b_i = 1'b1;
    chk(8'(lock_loss_flag), 8'h01);
    rd(8'h0A, 8'hFF, 8'h05, 1);
    rd(8'h0F, 8'hFF, 8'h00, 1);
    core(12'h0FA, 12'hFFF);
    chk(8'(lock_loss_flag), 8'h00);
    core(12'h3E8, 12'hFFF);
    chk(8'(lock_loss_flag), 8'h00);
    core(12'h3E9, 12'hFFF);
    chk(8'(lock_loss_flag), 8'h01);
    core(12'h0FB, 12'hFFF);
    chk(8'(lock_loss_flag), 8'h01);
    core(12'h0FA, 12'hFFF);
    chk(8'(lock_loss_flag), 8'h00);
    rd(8'h06, 8'h04, 8'h04, 1);
    wr(8'h08, 8'h04);
    rd(8'h06, 8'h04, 8'h04, 1);
    wr(8'h08, 8'h00);
    rd(8'h06, 8'h04, 8'h00, 1);
    wr(8'h09, 8'h10);
    chk(8'(lock_loss_flag), 8'h00);
    core(12'h3E9, 12'hFFF);
    core(12'h0FA, 12'hFFF);
    chk(8'(lock_loss_flag), 8'h01);
    wr(8'h08, 8'h30);
    chk({4'h0, refa, mode}, 8'h0B);
    head(8'h09);
    m.xfer(8'h00, 1'b1, rx, ack);
    m.xfer(8'h01, 1'b1, rx, ack);
    fin();
    chk(rctl, 8'h01);
    wr(8'h0F, 8'h1A);
    chk(rlk, 8'h1A);
    core(12'hFFF, 12'h0FA);
    chk(8'(lock_loss_flag), 8'h00);
    core(12'h000, 12'h3E9);
    chk(8'(lock_loss_flag), 8'h01);
    asel = 1'b0;
    m.start();
    m.xfer({cdrlk_pkg::ADDR_HI, ~asel, 1'b0}, 1'b1, rx, ack);
    chk(8'(ack), 8'h01);
    m.stop();
    head(8'h1F);
    chk(8'(ack), 8'h01);
    m.stop();
    for (int i = 0; i < 4; i++) begin
      wr(8'h1E, ov[i]);
      chk({5'h00, doff, coff, data_o}, ox[i]);
    end
    head(8'h1E);
    m.xfer(8'h22, 1'b1, rx, ack);
    m.xfer(8'h00, 1'b1, rx, ack);
    chk(8'(ack), 8'h01);
    fin();
    rd(8'h1E, 8'hFF, 8'h22, 2);
    test_done();
  end

  // Guard against a hang.
  initial begin
    repeat (20000) @(posedge clock_i);
    fail_count++;
    test_done();
  end
endmodule : test_cdr_lock_and_serial_control
